// *** hw/sdram_write_pkg.sv ***
// Shared constants and types for the synchronous DRAM write and precharge path.
package sdram_write_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int DATA_W = 16;
  localparam int COL_W = 9;
  localparam int ROW_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int AXI_ADDR_W = 8;
  localparam int PRECHARGE_ALL_SELECT_BIT = 10;
  localparam int AUTO_PRECHARGE_BIT = 10;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_RECOVERY_TIME_NS = 8;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int MASK_GUARD_PERIOD_NS = 15;
  localparam int WR_RAW = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_RAW = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WR_CYCLES = 4'((WR_RAW < 1) ? 1 : WR_RAW);
  localparam logic [3:0] RP_CYCLES = 4'((RP_RAW < 1) ? 1 : RP_RAW);
  localparam logic MASK_GUARD_NEEDED = (CLK_PERIOD_NS < MASK_GUARD_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [AXI_ADDR_W-1:0] MODE_CONFIG_OFFSET = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] ERROR_OFFSET = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] WRITE_COUNT_OFFSET = 8'h0C;
  localparam int BURST_CODE_LSB = 0;
  localparam int WRITE_BURST_MODE_BIT_POS = 9;
  localparam logic [2:0] MODE_BURST_CODE_RESET = 3'h0;
  localparam logic MODE_WRITE_BURST_RESET = 1'b0;
  localparam logic [2:0] BURST_CODE_1 = 3'h0;
  localparam logic [2:0] BURST_CODE_2 = 3'h1;
  localparam logic [2:0] BURST_CODE_4 = 3'h2;
  localparam logic [2:0] BURST_CODE_8 = 3'h3;
  localparam logic [2:0] BURST_CODE_PAGE = 3'h7;
  localparam int ERR_NOT_OPEN = 0;
  localparam int ERR_BANK_BUSY = 1;
  localparam int ERR_RECOVERY = 2;
  localparam int ERR_MASK = 3;
  localparam int ERR_TRUNC_AUTO = 4;
  localparam int ERR_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_TERMINATE, CMD_PRECHARGE,
                            CMD_OTHER} cmd_t;
  typedef enum logic [1:0] {BANK_IDLE, BANK_OPEN, BANK_RECOVERY, BANK_PRECHARGING} bank_state_t;

endpackage : sdram_write_pkg

// *** hw/column_stepper.sv ***
// Next column address of a write burst, wrapping inside the burst or the page.
`timescale 1ns/1ps
`default_nettype none
module column_stepper
  import sdram_write_pkg::*;
(
  input wire logic [COL_W-1:0] col,
  input wire logic [2:0] burst_code,
  input wire logic full_page,
  output logic [COL_W-1:0] next_col
);

  logic [COL_W-1:0] wrap_mask;
  logic [COL_W-1:0] col_inc;

  always_comb begin
    case (burst_code)
      BURST_CODE_2: wrap_mask = 9'h001;
      BURST_CODE_4: wrap_mask = 9'h003;
      BURST_CODE_8: wrap_mask = 9'h007;
      default: wrap_mask = 9'h000;
    endcase
    col_inc = col + 9'h001;
    if (full_page) begin
      next_col = col_inc; // [RL5]
    end else begin
      next_col = (col & ~wrap_mask) | (col_inc & wrap_mask);
    end
  end

endmodule : column_stepper
`default_nettype wire

// *** hw/bank_tracker.sv ***
// State of one bank: idle, open, waiting for write recovery, or precharging.
`timescale 1ns/1ps
`default_nettype none
module bank_tracker
  import sdram_write_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic activate,
  input wire logic precharge,
  input wire logic auto_precharge,
  input wire logic data_written,
  output bank_state_t state,
  output logic recovered
);

  typedef struct packed {
    bank_state_t state;
    logic [3:0] count;
    logic [3:0] since_write;
  } tracker_t;

  tracker_t s;
  tracker_t next_s;

  assign state = s.state;
  assign recovered = (s.since_write >= WR_CYCLES);

  always_comb begin
    next_s = s;
    if (s.since_write != WR_CYCLES) begin
      next_s.since_write = s.since_write + 4'h1;
    end
    if (data_written) begin
      next_s.since_write = 4'h1;
    end
    case (s.state)
      BANK_IDLE: begin
        if (activate) begin
          next_s.state = BANK_OPEN;
        end
      end
      BANK_OPEN: begin
        if (precharge) begin
          next_s.state = BANK_PRECHARGING;
          next_s.count = RP_CYCLES - 4'h1;
        end else if (auto_precharge) begin
          next_s.state = BANK_RECOVERY; // [RL2]
        end
      end
      BANK_RECOVERY: begin
        if (precharge || (recovered && !data_written)) begin
          next_s.state = BANK_PRECHARGING; // [RL11]
          next_s.count = RP_CYCLES - 4'h1;
        end
      end
      BANK_PRECHARGING: begin
        if (s.count == 4'h0) begin
          next_s.state = BANK_IDLE; // [RL20]
        end else begin
          next_s.count = s.count - 4'h1;
        end
      end
      default: next_s.state = BANK_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{state: BANK_IDLE, count: 4'h0, since_write: WR_CYCLES};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_recovery_before_precharge: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
    ($rose(s.state == BANK_PRECHARGING) && $past(s.state) == BANK_RECOVERY) |-> $past(recovered))
    else $error("Auto precharge began before write recovery.");
  a_precharge_period: assert property (@(posedge aclk) disable iff (!aresetn) // [RL20]
    $rose(s.state == BANK_PRECHARGING) |-> (s.state == BANK_PRECHARGING)[*5] ##1 s.state == BANK_IDLE)
    else $error("Precharge period has the wrong length.");
  c_auto_precharge: cover property (@(posedge aclk) disable iff (!aresetn)
    s.state == BANK_RECOVERY ##1 s.state == BANK_PRECHARGING);

endmodule : bank_tracker
`default_nettype wire

// *** hw/sdram_write_path.sv ***
// Write burst, burst truncation and precharge logic of a four-bank DRAM, with an AXI4-Lite register file.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// RL1 - WRITE carries column, bank and auto-precharge flag.
// RL2 - Auto precharge closes the row after the burst; the code drops the flag for full-page bursts.
// RL3 - First data captured with WRITE, then every edge.
// RL4 - Finished fixed burst ignores further input data.
// RL5 - Full-page burst runs on, column wraps to zero.
// RL6 - New WRITE ends old burst, owns its data.
// RL7 - WRITE accepted on every clock, any bank.
// RL8 - READ ends the burst; its data is ignored.
// RL9 - Controller precharges fixed burst only without auto.
// RL10 - Controller waits write recovery before precharge.
// RL11 - Auto precharge waits at least one recovery clock.
// RL12 - Controller masks data around a truncating precharge.
// RL13 - Controller waits precharge period before next command.
// RL14 - Terminate drops its own data, ends the burst.
// RL15 - Write burst mode bit forces single writes.
// RL16 - Precharge one bank, or all with select high.
// RL17 - Precharged bank is idle until activated again.
// RL18 - Length field governs writes when mode bit clear.
// RL19 - Controller activates a row before READ or WRITE.
// RL20 - Per-bank state tracks recovery and precharge timing.
module sdram_write_path
  import sdram_write_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ROW_W-1:0] addr,
  input wire logic data_mask,
  input wire logic [DATA_W-1:0] write_data_in,
  output logic array_write,
  output logic [BANK_W-1:0] array_bank,
  output logic [ROW_W-1:0] array_row,
  output logic [COL_W-1:0] array_col,
  output logic [DATA_W-1:0] array_data,
  output logic array_mask
);

  typedef struct packed {
    logic burst_active;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic [2:0] remaining;
    logic [2:0] run_code;
    logic full_page;
    logic auto_pre;
    logic [NUM_BANKS-1:0][ROW_W-1:0] rows;
    logic [2:0] burst_code;
    logic write_burst_mode_bit;
    logic [ERR_W-1:0] errors;
    logic [31:0] write_count;
    logic prev_mask;
    logic array_write;
    logic [BANK_W-1:0] array_bank;
    logic [ROW_W-1:0] array_row;
    logic [COL_W-1:0] array_col;
    logic [DATA_W-1:0] array_data;
    logic array_mask;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;
  cmd_t cmd;
  logic [BANK_W-1:0] cmd_bank;
  logic [COL_W-1:0] cmd_col;
  logic precharge_all_select;
  logic cmd_page;
  logic cmd_single;
  logic [2:0] len_m1;
  logic [COL_W-1:0] cmd_next_col;
  logic [COL_W-1:0] run_next_col;
  bank_state_t bank_state [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_recovered;
  logic [NUM_BANKS-1:0] activate_v;
  logic [NUM_BANKS-1:0] precharge_v;
  logic [NUM_BANKS-1:0] auto_v;
  logic [NUM_BANKS-1:0] written_v;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode; the bank bits, column and auto precharge flag come with it.
  assign cmd_bank = {bank_select_high, bank_select_low}; // [RL1]
  assign cmd_col = addr[COL_W-1:0];
  assign precharge_all_select = addr[PRECHARGE_ALL_SELECT_BIT];

  always_comb begin
    case ({chip_select_n, row_strobe_n, column_strobe_n, write_enable_n})
      4'h7: cmd = CMD_NOP;
      4'h3: cmd = CMD_ACTIVE;
      4'h5: cmd = CMD_READ;
      4'h4: cmd = CMD_WRITE;
      4'h6: cmd = CMD_TERMINATE;
      4'h2: cmd = CMD_PRECHARGE;
      default: cmd = chip_select_n ? CMD_NOP : CMD_OTHER;
    endcase
    case (s.burst_code)
      BURST_CODE_2: len_m1 = 3'h1;
      BURST_CODE_4: len_m1 = 3'h3;
      BURST_CODE_8: len_m1 = 3'h7;
      default: len_m1 = 3'h0;
    endcase
  end

  assign cmd_page = (s.burst_code == BURST_CODE_PAGE) && !s.write_burst_mode_bit;
  assign cmd_single = s.write_burst_mode_bit || (!cmd_page && len_m1 == 3'h0); // [RL15] [RL18]

  column_stepper u_cmd_step (
    .col(cmd_col),
    .burst_code(s.burst_code),
    .full_page(cmd_page),
    .next_col(cmd_next_col)
  );

  column_stepper u_run_step (
    .col(s.col),
    .burst_code(s.run_code),
    .full_page(s.full_page),
    .next_col(run_next_col)
  );

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    bank_tracker u_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .activate(activate_v[b]),
      .precharge(precharge_v[b]),
      .auto_precharge(auto_v[b]),
      .data_written(written_v[b]),
      .state(bank_state[b]),
      .recovered(bank_recovered[b])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst engine, bank commands and register file.
  always_comb begin
    logic [NUM_BANKS-1:0] targeted;
    logic [ERR_W-1:0] err_set;
    logic [ERR_W-1:0] err_clr;
    logic do_write;
    logic burst_end;
    logic [BANK_W-1:0] wr_bank;
    logic [COL_W-1:0] wr_col;
    next_s = s;
    targeted = precharge_all_select ? 4'hF : (4'h1 << cmd_bank); // [RL16]
    err_set = '0;
    err_clr = '0;
    do_write = 1'b0;
    wr_bank = s.bank;
    wr_col = s.col;
    activate_v = '0;
    precharge_v = '0;
    auto_v = '0;
    written_v = '0;
    burst_end = (cmd == CMD_WRITE) || (cmd == CMD_READ) || (cmd == CMD_TERMINATE) ||
                ((cmd == CMD_PRECHARGE) && targeted[s.bank]);
    next_s.prev_mask = data_mask;
    next_s.array_write = 1'b0;
    if (s.burst_active && burst_end) begin
      next_s.burst_active = 1'b0; // [RL6] [RL8] [RL14]
      if (s.auto_pre && cmd != CMD_PRECHARGE) begin
        auto_v[s.bank] = 1'b1; // [RL2]
      end
    end
    case (cmd)
      CMD_ACTIVE: begin
        if (bank_state[cmd_bank] == BANK_IDLE) begin
          activate_v[cmd_bank] = 1'b1; // [RL17]
          next_s.rows[cmd_bank] = addr;
        end else begin
          err_set[ERR_BANK_BUSY] = 1'b1; // [RL13]
        end
      end
      CMD_WRITE: begin
        if (bank_state[cmd_bank] == BANK_OPEN) begin
          do_write = 1'b1; // [RL3] [RL7]
          wr_bank = cmd_bank;
          wr_col = cmd_col;
          next_s.bank = cmd_bank;
          next_s.col = cmd_next_col;
          next_s.run_code = s.burst_code;
          next_s.full_page = cmd_page;
          next_s.auto_pre = addr[AUTO_PRECHARGE_BIT] && !cmd_page; // [RL1]
          next_s.burst_active = !cmd_single; // [RL15]
          next_s.remaining = len_m1 - 3'h1;
          if (cmd_single && addr[AUTO_PRECHARGE_BIT]) begin
            auto_v[cmd_bank] = 1'b1; // [RL2]
          end
        end else begin
          err_set[ERR_NOT_OPEN] = 1'b1; // [RL17]
        end
      end
      CMD_READ: begin
        if (bank_state[cmd_bank] != BANK_OPEN) begin
          err_set[ERR_NOT_OPEN] = 1'b1; // [RL17]
        end
      end
      CMD_PRECHARGE: begin
        precharge_v = targeted; // [RL16]
        if (s.burst_active && targeted[s.bank]) begin
          if (s.auto_pre) begin
            err_set[ERR_TRUNC_AUTO] = 1'b1; // [RL9]
          end
          if (MASK_GUARD_NEEDED && !(s.prev_mask && data_mask)) begin
            err_set[ERR_MASK] = 1'b1; // [RL12]
          end
        end
        for (int b = 0; b < NUM_BANKS; b++) begin
          if (targeted[b] && bank_state[b] == BANK_OPEN && !bank_recovered[b]) begin
            err_set[ERR_RECOVERY] = 1'b1; // [RL10]
          end
        end
      end
      default: begin
      end
    endcase
    if (s.burst_active && !burst_end) begin
      do_write = 1'b1; // [RL3]
      next_s.col = run_next_col; // [RL5]
      if (!s.full_page) begin
        if (s.remaining == 3'h0) begin
          next_s.burst_active = 1'b0; // [RL4]
          if (s.auto_pre) begin
            auto_v[s.bank] = 1'b1; // [RL2]
          end
        end else begin
          next_s.remaining = s.remaining - 3'h1;
        end
      end
    end
    if (do_write) begin
      written_v[wr_bank] = 1'b1;
      next_s.array_write = 1'b1;
      next_s.array_bank = wr_bank;
      next_s.array_row = s.rows[wr_bank];
      next_s.array_col = wr_col;
      next_s.array_data = write_data_in;
      next_s.array_mask = data_mask;
      if (!data_mask) begin
        next_s.write_count = s.write_count + 32'h0000_0001;
      end
    end
    // AXI4-Lite write channel: address and data in either order, response after both.
    if (awvalid && !s.aw_held && !s.bvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && !s.w_held && !s.bvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case ({s.aw_addr[AXI_ADDR_W-1:2], 2'h0})
        MODE_CONFIG_OFFSET: begin
          if (s.w_strb[0]) begin
            next_s.burst_code = s.w_data[BURST_CODE_LSB +: 3]; // [RL18]
          end
          if (s.w_strb[1]) begin
            next_s.write_burst_mode_bit = s.w_data[WRITE_BURST_MODE_BIT_POS]; // [RL15]
          end
        end
        ERROR_OFFSET: begin
          if (s.w_strb[0]) begin
            err_clr = s.w_data[ERR_W-1:0];
          end
        end
        STATUS_OFFSET, WRITE_COUNT_OFFSET: begin
        end
        default: next_s.bresp = RESP_DECERR;
      endcase
    end
    next_s.errors = (s.errors & ~err_clr) | err_set;
    // AXI4-Lite read channel.
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case ({araddr[AXI_ADDR_W-1:2], 2'h0})
        MODE_CONFIG_OFFSET: next_s.rdata = {22'h00_0000, s.write_burst_mode_bit, 6'h00, s.burst_code};
        STATUS_OFFSET: next_s.rdata = {23'h00_0000, s.burst_active, bank_state[3], bank_state[2],
                                       bank_state[1], bank_state[0]};
        ERROR_OFFSET: next_s.rdata = {27'h000_0000, s.errors};
        WRITE_COUNT_OFFSET: next_s.rdata = s.write_count;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.burst_code <= MODE_BURST_CODE_RESET;
      s.write_burst_mode_bit <= MODE_WRITE_BURST_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign array_write = s.array_write;
  assign array_bank = s.array_bank;
  assign array_row = s.array_row;
  assign array_col = s.array_col;
  assign array_data = s.array_data;
  assign array_mask = s.array_mask;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_capture: assert property ( // [RL3]
    (cmd == CMD_WRITE && bank_state[cmd_bank] == BANK_OPEN) |=>
      (array_write && array_col == $past(cmd_col) && array_data == $past(write_data_in)))
    else $error("WRITE data was not captured on the command edge.");
  a_read_stops: assert property ((cmd == CMD_READ) |=> !array_write) // [RL8]
    else $error("A write happened on a READ edge.");
  a_terminate_drop: assert property ((cmd == CMD_TERMINATE) |=> !array_write) // [RL14]
    else $error("Data given with burst terminate was written.");
  a_single_write: assert property ( // [RL15]
    (cmd == CMD_WRITE && s.write_burst_mode_bit && bank_state[cmd_bank] == BANK_OPEN) ##1 cmd == CMD_NOP
      |=> !array_write)
    else $error("Write burst mode bit did not force a single write.");
  a_burst_two_end: assert property ( // [RL4]
    (cmd == CMD_WRITE && !s.write_burst_mode_bit && s.burst_code == BURST_CODE_2 &&
     bank_state[cmd_bank] == BANK_OPEN) ##1 cmd == CMD_NOP ##1 cmd == CMD_NOP |-> array_write ##1 !array_write)
    else $error("Burst of two did not write two elements and stop.");
  a_page_wrap: assert property ( // [RL5]
    (s.burst_active && s.full_page && s.col == 9'h1FF && cmd == CMD_NOP) |=>
      (array_write && array_col == 9'h1FF && s.col == 9'h000))
    else $error("Full-page burst did not wrap to column zero.");
  a_new_write_owns: assert property ( // [RL6]
    (s.burst_active && cmd == CMD_WRITE && bank_state[cmd_bank] == BANK_OPEN) |=>
      (array_col == $past(cmd_col) && array_bank == $past(cmd_bank)))
    else $error("Data with a new WRITE went to the old burst.");
  a_precharge_all: assert property ( // [RL16]
    (cmd == CMD_PRECHARGE && precharge_all_select) |=>
      (bank_state[0] != BANK_OPEN && bank_state[1] != BANK_OPEN &&
       bank_state[2] != BANK_OPEN && bank_state[3] != BANK_OPEN))
    else $error("Precharge all left a bank open.");
  a_precharge_one: assert property ( // [RL16]
    (cmd == CMD_PRECHARGE && !precharge_all_select && cmd_bank == 2'h0 &&
     bank_state[0] == BANK_OPEN && bank_state[1] == BANK_OPEN) |=>
      (bank_state[0] == BANK_PRECHARGING && bank_state[1] == BANK_OPEN))
    else $error("Single-bank precharge hit the wrong bank.");
  a_not_open_flag: assert property ( // [RL17]
    (cmd == CMD_WRITE && bank_state[cmd_bank] != BANK_OPEN) |=> (s.errors[ERR_NOT_OPEN] && !array_write))
    else $error("WRITE to a closed bank was not refused and flagged.");
  a_bresp_hold: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("Write response dropped before it was taken.");

  c_burst_write: cover property (cmd == CMD_WRITE ##1 array_write ##1 array_write);
  c_page_wrap: cover property (s.full_page && s.col == 9'h1FF ##1 s.col == 9'h000);
  c_precharge_all: cover property (cmd == CMD_PRECHARGE && precharge_all_select);
  c_back_to_back: cover property (cmd == CMD_WRITE ##1 cmd == CMD_WRITE);

endmodule : sdram_write_path
`default_nettype wire

// *** tb/dram_ctrl_model.sv ***
// Controller-side model driving DRAM commands, bank, address, mask and write data.
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model
  import sdram_write_pkg::*;
(
  input wire logic aclk,
  output logic [3:0] cmd,
  output logic [1:0] bk,
  output logic [12:0] ad,
  output logic dm,
  output logic [15:0] dq
);
  initial {cmd, bk, ad, dm, dq} = {4'hf, 32'h0};
  // One command or data element per edge; idle edges invert the data lines.
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic m, input logic [15:0] d);
    @(posedge aclk);
    {cmd, bk, ad, dm, dq} <= {c, b, a, m, d};
  endtask : issue
  task automatic idle(input int n);
    repeat (n) issue(4'hf, bk, ad, 1'b0, ~dq);
  endtask : idle
  // A row is opened before any access to its bank.
  task automatic act(input logic [1:0] b, input logic [12:0] r);
    issue(4'h3, b, r, 1'b0, ~dq);
    idle(2);
  endtask : act
  // Recovery wait, mask around the precharge, then the precharge period.
  task automatic close(input logic [1:0] b, input logic all);
    repeat (WR_CYCLES) issue(4'hf, b, 13'h0, 1'b1, ~dq);
    issue(4'h2, b, 13'(all) << PRECHARGE_ALL_SELECT_BIT, 1'b1, ~dq);
    idle(RP_CYCLES);
  endtask : close
endmodule : dram_ctrl_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the DRAM write and precharge path.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h", $time, a); end end
module tb_top
  import sdram_write_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, array_write, array_mask, dm;
  logic [1:0] bresp, rresp, bk, array_bank;
  logic [31:0] rdata;
  logic [3:0] cmd;
  logic [12:0] ad, array_row;
  logic [12:0] rw [4];
  logic [8:0] array_col;
  logic [15:0] dq, array_data;
  logic [40:0] q [$];
  int fail_count = 0, num_checks = 0, cyc = 0, nw = 0;
  int lens [5] = '{1, 2, 4, 8, 512};
  int codes [5] = '{0, 1, 2, 3, 7};
  always #2 aclk = ~aclk;
  dram_ctrl_model u_ctrl (.aclk, .cmd, .bk, .ad, .dm, .dq);
  sdram_write_path u_dut (.*, .chip_select_n(cmd[3]), .row_strobe_n(cmd[2]), .column_strobe_n(cmd[1]),
    .write_enable_n(cmd[0]), .bank_select_low(bk[0]), .bank_select_high(bk[1]), .addr(ad), .data_mask(dm),
    .write_data_in(dq));
  task automatic end_sim;
    `CHK(q.size(), 0)
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge aclk) begin
    if (array_write === 1'b1) begin
      if (q.size() == 0) `CHK(array_write, 1'b0)
      else `CHK({array_bank, array_row, array_col, array_data, array_mask}, q.pop_front())
    end
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    `CHK(bresp, r)
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    `CHK({rdata, rresp}, {e, r})
    rready <= 1'b0;
  endtask : axr
  task automatic wr(input int b, c, n, l, input logic ap, ok);
    logic [15:0] d;
    for (int i = 0; i < n; i++) begin
      d = 16'($urandom);
      u_ctrl.issue(i ? 4'hf : 4'h4, 2'(b), i ? 13'h0 : {2'b0, ap, 1'b0, 9'(c)}, 1'b0, d);
      if (ok) begin
        q.push_back({2'(b), rw[b], 9'((c & ~(l - 1)) | ((c + i) & (l - 1))), d, 1'b0});
        nw++;
      end
    end
  endtask : wr
  initial begin
    void'($urandom(32'he152));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axr(MODE_CONFIG_OFFSET, 32'h0, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_DECERR);
    axw(8'h10, 32'hffff_ffff, RESP_DECERR);
    for (int b = 0; b < 4; b++) begin
      rw[b] = 13'($urandom);
      u_ctrl.act(2'(b), rw[b]);
    end
    u_ctrl.act(2'h0, 13'h0);
    axr(ERROR_OFFSET, 32'h0000_0002, RESP_OKAY);
    axw(ERROR_OFFSET, 32'h0000_0002, RESP_OKAY);
    axr(STATUS_OFFSET, 32'h0000_0055, RESP_OKAY);
    $display("done regs");
    foreach (codes[k]) begin
      axw(MODE_CONFIG_OFFSET, 32'(codes[k]), RESP_OKAY);
      wr(0, k == 4 ? 510 : $urandom, k == 4 ? 4 : lens[k], lens[k], 1'b0, 1'b1);
      u_ctrl.issue(k == 4 ? 4'h6 : 4'hf, 2'h0, 13'h0, 1'b0, 16'($urandom));
      wr(1, $urandom, 1, lens[k], 1'b0, 1'b1);
      wr(0, $urandom, 1, lens[k], 1'b0, 1'b1);
      u_ctrl.issue(4'h5, 2'h0, 13'h0, 1'b0, 16'($urandom));
      u_ctrl.idle(3);
    end
    $display("done bursts");
    axw(MODE_CONFIG_OFFSET, 32'h0000_0203, RESP_OKAY);
    axr(MODE_CONFIG_OFFSET, 32'h0000_0203, RESP_OKAY);
    wr(2, $urandom, 1, 1, 1'b0, 1'b1);
    u_ctrl.idle(8);
    axw(MODE_CONFIG_OFFSET, 32'h0000_0001, RESP_OKAY);
    wr(3, $urandom, 2, 2, 1'b1, 1'b1);
    u_ctrl.idle(WR_CYCLES + RP_CYCLES + 2);
    wr(3, $urandom, 1, 2, 1'b0, 1'b0);
    u_ctrl.idle(3);
    axr(ERROR_OFFSET, 32'h1, RESP_OKAY);
    axw(ERROR_OFFSET, 32'h1, RESP_OKAY);
    axr(ERROR_OFFSET, 32'h0, RESP_OKAY);
    $display("done auto precharge");
    u_ctrl.close(2'h0, 1'b0);
    wr(0, $urandom, 1, 2, 1'b0, 1'b0);
    wr(1, $urandom, 2, 2, 1'b0, 1'b1);
    u_ctrl.close(2'h1, 1'b1);
    wr(2, $urandom, 1, 2, 1'b0, 1'b0);
    u_ctrl.idle(3);
    axr(ERROR_OFFSET, 32'h1, RESP_OKAY);
    axr(WRITE_COUNT_OFFSET, 32'(nw), RESP_OKAY);
    $display("done precharge");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
